// ===== rtl/hcca_params.svh
`ifndef HCCA_PARAMS_SVH
`define HCCA_PARAMS_SVH

// command codes
`define HCCA_CMD_CTRL_READ 8'h68
`define HCCA_CMD_CTRL_WRITE 8'h78

// result codes in the low nibble of the status byte
`define HCCA_RES_NORMAL 4'h5
`define HCCA_RES_BUSY 4'h7
`define HCCA_RES_UNIMPL 4'h8
`define HCCA_RES_PARAM 4'hA
`define HCCA_RES_DIAG 4'hB

// control data byte fields
`define HCCA_CTL_MASK_MSB 7
`define HCCA_CTL_MASK_LSB 4
`define HCCA_CTL_RF_STOP 3
`define HCCA_CTL_RSVD_ONE 2
`define HCCA_CTL_CFG_ERR 1
`define HCCA_CTL_BCC_ERR 0
`define HCCA_CTL_RESET_REQ 0
`define HCCA_CTL_RESET 8'h00

// seven-bit bus address, value is arbitrary
`define HCCA_SLAVE_ADDR 7'h52

// timing
`define HCCA_CLK_MHZ 50
`define HCCA_SELF_RESET_US 3000
`define HCCA_SELF_RESET_CYC (`HCCA_SELF_RESET_US * `HCCA_CLK_MHZ)
`define HCCA_WIN_UNIT_US 1
`define HCCA_WIN_UNIT_CYC (`HCCA_WIN_UNIT_US * `HCCA_CLK_MHZ)

`endif

// ===== rtl/hcca_pkg.sv
package hcca_pkg;

	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_ADDR = 2'b01,
		LK_WR = 2'b10,
		LK_RD = 2'b11
	} hcca_link_e;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SPLIT = 2'b01,
		PH_SELF_RESET = 2'b10
	} hcca_phase_e;

	typedef struct packed {
		hcca_link_e state;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic rw;
		logic ack;
		logic start_seen;
		logic addr_tgl;
		logic wr_tgl;
		logic rd_tgl;
		logic [7:0] wr_byte;
	} hcca_link_s;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		logic loaded;
		logic [7:0] ctrl;
		logic [7:0] cmd0;
		logic [7:0] cmd1;
		logic [1:0] cmd_cnt;
		logic in_write;
		logic [7:0] resp0;
		logic [7:0] resp1;
		logic [1:0] resp_len;
		logic resp_valid;
		logic [1:0] sent_idx;
		logic part2;
		logic p2_sent;
		logic status_sent;
		hcca_phase_e phase;
		logic win_on;
		logic [7:0] win_units;
		logic [5:0] presc;
		logic sr_pend;
		logic [17:0] sr_cnt;
		logic [3:0] rf_pend;
		logic irq_resp;
		logic irq_low;
		logic sr_active;
		logic [7:0] tx_byte;
	} hcca_core_s;

endpackage

// ===== rtl/hcca_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "hcca_params.svh"

module hcca_link (
	// link clock and reset
	input wire logic scl_clk,
	input wire logic resetn,
	// bus data pin
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// core side, toggles mark events
	input wire logic [7:0] tx_byte,
	output logic addr_tgl,
	output logic wr_tgl,
	output logic rd_tgl,
	output logic stop_tgl,
	output logic rw,
	output logic [7:0] wr_byte
);

	hcca_pkg::hcca_link_s q, d;
	logic start_tgl;
	logic [7:0] rx_byte;

	////////////////////////////////////////////////////////////////////////////
	// start and stop are sda edges while scl is high; only these two flops see sda as a clock
	always_ff @(negedge sda_in or negedge resetn) begin
		if (!resetn) begin
			start_tgl <= 1'b0;
		end else if (scl_clk) begin
			start_tgl <= ~start_tgl;
		end
	end

	always_ff @(posedge sda_in or negedge resetn) begin
		if (!resetn) begin
			stop_tgl <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl <= ~stop_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign rx_byte = {q.sh[6:0], sda_in};

	always_comb begin
		d = q;
		if (start_tgl != q.start_seen) begin
			d.start_seen = start_tgl;
			d.state = hcca_pkg::LK_ADDR;
			d.cnt = 4'h1;
			d.sh = {7'h00, sda_in};
			d.ack = 1'b0;
		end else begin
			case (q.state)
				hcca_pkg::LK_ADDR, hcca_pkg::LK_WR: begin
					if (q.cnt == 4'h8) begin
						d.ack = 1'b0;
						d.cnt = 4'h0;
						if (q.state == hcca_pkg::LK_ADDR) begin
							d.state = q.rw ? hcca_pkg::LK_RD : hcca_pkg::LK_WR;
							if (q.rw) begin
								d.tx = tx_byte;
								d.rd_tgl = ~q.rd_tgl;
							end
						end
					end else begin
						d.sh = rx_byte;
						d.cnt = q.cnt + 4'h1;
						if (q.cnt == 4'h7 && q.state == hcca_pkg::LK_ADDR) begin
							if (rx_byte[7:1] == `HCCA_SLAVE_ADDR) begin
								d.ack = 1'b1;
								d.rw = rx_byte[0];
								d.addr_tgl = ~q.addr_tgl;
							end else begin
								d.state = hcca_pkg::LK_IDLE;
							end
						end else if (q.cnt == 4'h7) begin
							d.wr_byte = rx_byte;
							d.wr_tgl = ~q.wr_tgl;
							d.ack = 1'b1;
						end
					end
				end
				hcca_pkg::LK_RD: begin
					if (q.cnt == 4'h8) begin
						if (sda_in) begin
							d.state = hcca_pkg::LK_IDLE;
						end else begin
							d.tx = tx_byte;
							d.rd_tgl = ~q.rd_tgl;
							d.cnt = 4'h0;
						end
					end else begin
						d.cnt = q.cnt + 4'h1;
						d.tx = {q.tx[6:0], 1'b0};
					end
				end
				default: begin
					d = q;
				end
			endcase
		end
	end

	always_ff @(posedge scl_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// data changes only while scl is low
	always_ff @(negedge scl_clk or negedge resetn) begin
		if (!resetn) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_oe <= (q.cnt == 4'h8 && q.ack) ||
				(q.state == hcca_pkg::LK_RD && q.cnt != 4'h8 && !q.tx[7]);
			sda_out <= 1'b0;
		end
	end

	assign addr_tgl = q.addr_tgl;
	assign wr_tgl = q.wr_tgl;
	assign rd_tgl = q.rd_tgl;
	assign rw = q.rw;
	assign wr_byte = q.wr_byte;

endmodule // hcca_link
`default_nettype wire

// ===== rtl/hcca_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hcca_params.svh"

// Behaviour
// - control read returns status then data; bits 7:4 masks, bit 3 rf stop.
// - bit 2 of control read data always reads one.
// - bit 1 of control read data is the configuration check error.
// - bit 0 of control read data is the block check code error.
// - control write is code plus one data byte; answer is one status byte.
// - write bits 7:4 suppress write, read, transmit, field interrupts; default zero.
// - write bit 3 stops rf; loaded from rf enable default after power-on.
// - write bit 0 self-resets after response is sent; reloads settings.
// - access during self-reset gets busy status.
// - any read with nothing pending is the status command; one status byte.
// - commands and responses may be split on byte boundaries; device reassembles.
// - device acknowledges its write address and every command byte.
// - after processing a command, irq output goes low for response ready.
// - read address match acknowledged, irq released, status byte sent first.
// - second part of split response starts with self-diagnosis status byte.
// - a split transfer has at most two parts.
// - control read command is the single code byte.
// - status low nibble is result code, high nibble pending interrupt flags.
// - during rf processing, control read is normal, control write is parameter error.
module hcca_top #(
	parameter int unsigned SELF_RESET_CYC = `HCCA_SELF_RESET_CYC
) (
	// clocks and reset
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic scl_clk,
	// serial pins
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic irq_out_n,
	output logic irq_out_oe,
	// system settings
	input wire logic rf_enable_default,
	input wire logic [3:0] irq_source_select,
	input wire logic [7:0] response_wait_window,
	input wire logic config_check_err,
	input wire logic block_check_code_err,
	// rf side
	input wire logic rf_busy,
	input wire logic [3:0] rf_events,
	// control outputs
	output logic [7:0] interrupt_mask_control,
	output logic self_reset_active
);

	localparam int unsigned WIN_UNIT_CYC = `HCCA_WIN_UNIT_CYC;

	hcca_pkg::hcca_core_s q, d;
	logic addr_tgl, wr_tgl, rd_tgl, stop_tgl, link_rw;
	logic [7:0] wr_byte;
	logic [4:0] ev;
	logic [3:0] result_now;
	logic [3:0] rf_set;
	logic exec;
	logic [7:0] code;

	hcca_link u_link (
		.scl_clk(scl_clk),
		.resetn(resetn),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.tx_byte(q.tx_byte),
		.addr_tgl(addr_tgl),
		.wr_tgl(wr_tgl),
		.rd_tgl(rd_tgl),
		.stop_tgl(stop_tgl),
		.rw(link_rw),
		.wr_byte(wr_byte)
	);

	// per-source request: the source must be selected and not masked
	for (genvar gi = 0; gi < 4; gi++) begin : g_rf_src
		assign rf_set[gi] = rf_events[gi] && irq_source_select[gi] &&
			!q.ctrl[`HCCA_CTL_MASK_LSB + gi];
	end

	////////////////////////////////////////////////////////////////////////////
	// event order in ev: 0 address, 1 write byte, 2 read byte loaded, 3 stop, 4 rw change
	assign ev = q.s2 ^ q.s3;
	assign code = q.cmd0;
	assign result_now = (q.phase == hcca_pkg::PH_SELF_RESET || rf_busy) ?
		`HCCA_RES_BUSY : `HCCA_RES_NORMAL;

	always_comb begin
		d = q;
		exec = 1'b0;
		d.s1 = {link_rw, stop_tgl, rd_tgl, wr_tgl, addr_tgl};
		d.s2 = q.s1;
		d.s3 = {q.s2[4], q.s2[3:0]};

		// settings are reloaded on the first cycle after reset
		if (!q.loaded) begin
			d.loaded = 1'b1;
			d.ctrl = `HCCA_CTL_RESET;
			d.ctrl[`HCCA_CTL_RF_STOP] = ~rf_enable_default;
		end

		// response wait window, counted in whole units
		if (q.win_on) begin
			if (q.presc == 6'(WIN_UNIT_CYC - 1)) begin
				d.presc = 6'h00;
				d.win_units = q.win_units + 8'h01;
				if (q.win_units >= response_wait_window) begin
					// window expired: the half command or half response is dropped
					d.win_on = 1'b0;
					d.phase = hcca_pkg::PH_IDLE;
					d.cmd_cnt = 2'h0;
					d.resp_valid = 1'b0;
					d.part2 = 1'b0;
				end
			end else begin
				d.presc = q.presc + 6'h01;
			end
		end

		// address match starts a transaction
		if (ev[0]) begin
			d.in_write = ~q.s2[4];
			d.status_sent = 1'b0;
			if (q.s2[4]) begin
				d.irq_resp = 1'b0;
				d.win_on = 1'b0;
			end else if (q.phase != hcca_pkg::PH_SPLIT) begin
				d.cmd_cnt = 2'h0;
			end else begin
				d.win_on = 1'b0;
			end
		end

		// command bytes, anything past two is ignored
		if (ev[1] && q.cmd_cnt != 2'h2) begin
			if (q.cmd_cnt == 2'h0) begin
				d.cmd0 = wr_byte;
			end else begin
				d.cmd1 = wr_byte;
			end
			d.cmd_cnt = q.cmd_cnt + 2'h1;
		end

		// a byte was taken by the link; move to the next one
		if (ev[2]) begin
			// unconditional: set after the address event, so it wins over that clear in this same cycle
			d.status_sent = 1'b1;
			if (!q.resp_valid) begin
				d.rf_pend = 4'h0;
			end else if (q.part2 && !q.p2_sent) begin
				d.p2_sent = 1'b1;
			end else begin
				if (q.sent_idx == 2'h0) begin
					d.rf_pend = 4'h0;
				end
				d.sent_idx = q.sent_idx + 2'h1;
			end
		end

		// stop closes the transaction
		if (ev[3]) begin
			if (q.in_write && q.cmd_cnt != 2'h0) begin
				if (code == `HCCA_CMD_CTRL_WRITE && q.cmd_cnt == 2'h1 &&
					q.phase == hcca_pkg::PH_IDLE) begin
					d.phase = hcca_pkg::PH_SPLIT;
					d.win_on = 1'b1;
					d.win_units = 8'h00;
					d.presc = 6'h00;
				end else begin
					exec = 1'b1;
				end
			end else if (!q.in_write && q.resp_valid && q.status_sent) begin
				if (q.sent_idx >= q.resp_len) begin
					d.resp_valid = 1'b0;
					d.part2 = 1'b0;
					if (q.sr_pend) begin
						d.sr_pend = 1'b0;
						d.phase = hcca_pkg::PH_SELF_RESET;
						d.sr_cnt = 18'h0_0000;
					end
				end else if (!q.part2) begin
					d.part2 = 1'b1;
					d.p2_sent = 1'b0;
					d.win_on = 1'b1;
					d.win_units = 8'h00;
					d.presc = 6'h00;
				end else begin
					d.resp_valid = 1'b0;
					d.part2 = 1'b0;
				end
			end
		end

		// command processing
		if (exec) begin
			d.cmd_cnt = 2'h0;
			d.resp_valid = 1'b1;
			d.resp_len = 2'h1;
			d.sent_idx = 2'h0;
			d.part2 = 1'b0;
			d.irq_resp = 1'b1;
			if (q.phase == hcca_pkg::PH_SELF_RESET) begin
				d.resp0 = {q.rf_pend, `HCCA_RES_BUSY};
			end else begin
				d.phase = hcca_pkg::PH_IDLE;
				if (code == `HCCA_CMD_CTRL_READ) begin
					d.resp0 = {q.rf_pend, `HCCA_RES_NORMAL};
					d.resp1 = {q.ctrl[7:3], 1'b1, config_check_err,
						block_check_code_err};
					d.resp_len = 2'h2;
				end else if (code == `HCCA_CMD_CTRL_WRITE && q.cmd_cnt == 2'h2) begin
					if (rf_busy) begin
						d.resp0 = {q.rf_pend, `HCCA_RES_PARAM};
					end else begin
						// reserved bits 2:1 are not stored, so stray ones are harmless
						d.ctrl = {q.cmd1[7:3], 3'b000};
						d.sr_pend = q.cmd1[`HCCA_CTL_RESET_REQ];
						d.resp0 = {q.rf_pend, `HCCA_RES_NORMAL};
					end
				end else begin
					d.resp0 = {q.rf_pend, `HCCA_RES_UNIMPL};
				end
			end
		end

		// self-reset period, then reinitialise from settings
		if (q.phase == hcca_pkg::PH_SELF_RESET) begin
			if (q.sr_cnt == 18'(SELF_RESET_CYC - 1)) begin
				d.phase = hcca_pkg::PH_IDLE;
				d.ctrl = `HCCA_CTL_RESET;
				d.ctrl[`HCCA_CTL_RF_STOP] = ~rf_enable_default;
				d.rf_pend = 4'h0;
			end else begin
				d.sr_cnt = q.sr_cnt + 18'h0_0001;
			end
		end

		// rf interrupt flags, set wins over the clear above
		d.rf_pend = d.rf_pend | rf_set;

		d.irq_low = d.irq_resp || (|d.rf_pend);
		d.sr_active = (d.phase == hcca_pkg::PH_SELF_RESET);

		// next byte for the link is prepared ahead, so the link never waits on the core
		if (!d.resp_valid) begin
			d.tx_byte = {d.rf_pend, result_now};
		end else if (d.part2 && !d.p2_sent) begin
			d.tx_byte = {d.rf_pend, `HCCA_RES_DIAG};
		end else if (d.sent_idx == 2'h0) begin
			d.tx_byte = d.resp0;
		end else if (d.sent_idx == 2'h1 && d.resp_len == 2'h2) begin
			d.tx_byte = d.resp1;
		end else begin
			d.tx_byte = 8'hFF;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign irq_out_n = 1'b0;
	assign irq_out_oe = q.irq_low;
	assign interrupt_mask_control = q.ctrl;
	assign self_reset_active = q.sr_active;

endmodule // hcca_top
`default_nettype wire

// ===== bench/hcca_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module hcca_top_assertions #(
	parameter int unsigned SELF_RESET_CYC = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// pins
	input wire logic sda_out,
	input wire logic irq_out_n,
	input wire logic irq_out_oe,
	// settings and rf side
	input wire logic rf_enable_default,
	input wire logic [3:0] irq_source_select,
	input wire logic rf_busy,
	input wire logic [3:0] rf_events,
	// control outputs
	input wire logic [7:0] interrupt_mask_control,
	input wire logic self_reset_active
);
	int unsigned sr_len_q;

	// length of the current self-reset period, in core cycles
	always_ff @(posedge core_clk) begin
		if (!resetn || !self_reset_active) begin
			sr_len_q <= 0;
		end else begin
			sr_len_q <= sr_len_q + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (!resetn)
		sda_out == 1'b0 && irq_out_n == 1'b0) else $error("pin value not low");
	AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
		interrupt_mask_control[2:0] == 3'b000) else $error("control low bits set");
	AST_RESET_DEFAULT: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(resetn) |-> interrupt_mask_control == 8'h00 && !irq_out_oe && !self_reset_active)
		else $error("outputs not cleared by reset");
	AST_RESET_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(resetn) |-> ##[1:2] interrupt_mask_control[3] == !rf_enable_default)
		else $error("rf stop not loaded after reset");
	AST_BUSY_STABLE: assert property (@(posedge core_clk) disable iff (!resetn)
		rf_busy && $past(rf_busy) && !self_reset_active && !$past(self_reset_active)
		|-> $stable(interrupt_mask_control)) else $error("control changed while rf busy");
	AST_SR_MAX: assert property (@(posedge core_clk) disable iff (!resetn)
		sr_len_q <= SELF_RESET_CYC + 1) else $error("self reset too long");
	AST_SR_MIN: assert property (@(posedge core_clk) disable iff (!resetn)
		$fell(self_reset_active) |-> sr_len_q >= SELF_RESET_CYC - 1)
		else $error("self reset too short");
	AST_SR_RELOAD: assert property (@(posedge core_clk) disable iff (!resetn)
		$fell(self_reset_active) |-> ##[0:2]
		interrupt_mask_control == {4'h0, !rf_enable_default, 3'b000})
		else $error("control not reloaded after self reset");
	AST_IRQ_SRC: assert property (@(posedge core_clk) disable iff (!resetn)
		(rf_events & irq_source_select & ~interrupt_mask_control[7:4]) != 4'h0
		|-> ##[1:4] irq_out_oe) else $error("enabled rf event gave no irq");
endmodule // hcca_top_assertions

bind hcca_top hcca_top_assertions #(.SELF_RESET_CYC(SELF_RESET_CYC)) hcca_top_assertions_i (
	.core_clk(core_clk),
	.resetn(resetn),
	.sda_out(sda_out),
	.irq_out_n(irq_out_n),
	.irq_out_oe(irq_out_oe),
	.rf_enable_default(rf_enable_default),
	.irq_source_select(irq_source_select),
	.rf_busy(rf_busy),
	.rf_events(rf_events),
	.interrupt_mask_control(interrupt_mask_control),
	.self_reset_active(self_reset_active)
);

`default_nettype wire

// ===== bench/hcca_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hcca_host_model (
	// bus wires, resolved here with the pull-up
	output logic scl,
	output wire logic sda,
	// device pull-down on sda
	input wire logic dev_sda_oe
);
	logic drive_low;

	assign sda = !(drive_low || dev_sda_oe);

	initial begin
		scl = 1'b1;
		drive_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// the long high phase of the ninth bit leaves the core time to answer
	task automatic clk_bit(input logic b, output logic r, input realtime hi);
		drive_low = !b;
		#3.5 scl = 1'b1;
		#3 r = sda;
		#(hi) scl = 1'b0;
		#4;
	endtask

	task automatic send(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], r, 4.5);
		clk_bit(1'b1, ack, 200);
	endtask

	task automatic recv(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i], 4.5);
		clk_bit(last, r, 200);
	endtask

	task automatic start_frame(input logic [7:0] addr_rw, output logic ack);
		drive_low = 1'b1;
		#8 scl = 1'b0;
		#4;
		send(addr_rw, ack);
	endtask

	// scl then stands still high, as the bus does between frames
	task automatic stop_frame();
		drive_low = 1'b1;
		#3.5 scl = 1'b1;
		#8 drive_low = 1'b0;
		#120;
	endtask
endmodule // hcca_host_model

`default_nettype wire

// ===== bench/host_control_command_access_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "hcca_params.svh"

module host_control_command_access_test;
	localparam int unsigned SR_CYC = 200;
	logic core_clk = 1'b0;
	logic resetn = 1'b1;
	logic scl_clk;
	logic sda_line;
	logic sda_out;
	logic sda_oe;
	logic irq_out_n;
	logic irq_out_oe;
	logic self_reset_active;
	logic rf_enable_default = 1'b0;
	logic rf_busy = 1'b0;
	logic [3:0] irq_source_select = 4'hF;
	logic [3:0] rf_events = 4'h0;
	logic config_check_err = 1'b1;
	logic block_check_code_err = 1'b0;
	logic [7:0] interrupt_mask_control;
	int err_count = 0;
	int checks_done = 0;

	always #10 core_clk = ~core_clk;

	hcca_top #(.SELF_RESET_CYC(SR_CYC)) hcca_top_i (
		.core_clk(core_clk),
		.resetn(resetn),
		.scl_clk(scl_clk),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.irq_out_n(irq_out_n),
		.irq_out_oe(irq_out_oe),
		.rf_enable_default(rf_enable_default),
		.irq_source_select(irq_source_select),
		.response_wait_window(8'h14),
		.config_check_err(config_check_err),
		.block_check_code_err(block_check_code_err),
		.rf_busy(rf_busy),
		.rf_events(rf_events),
		.interrupt_mask_control(interrupt_mask_control),
		.self_reset_active(self_reset_active)
	);

	hcca_host_model hcca_host_model_i (.scl(scl_clk), .sda(sda_line), .dev_sda_oe(sda_oe));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input int n);
		logic a;
		hcca_host_model_i.start_frame({`HCCA_SLAVE_ADDR, 1'b0}, a);
		cmp1(a, 1'b0);
		hcca_host_model_i.send(b0, a);
		cmp1(a, 1'b0);
		if (n > 1) begin
			hcca_host_model_i.send(b1, a);
			cmp1(a, 1'b0);
		end
		hcca_host_model_i.stop_frame();
	endtask

	task automatic rd(input int n, input logic [15:0] exp);
		logic a;
		logic [7:0] v;
		hcca_host_model_i.start_frame({`HCCA_SLAVE_ADDR, 1'b1}, a);
		cmp1(a, 1'b0);
		hcca_host_model_i.recv(n == 1, v);
		cmp8(v, exp[15:8]);
		if (n > 1) begin
			hcca_host_model_i.recv(1'b1, v);
			cmp8(v, exp[7:0]);
		end
		hcca_host_model_i.stop_frame();
		@(negedge core_clk);
		cmp1(irq_out_oe, 1'b0);
	endtask

	// bounded wait for the response-ready line
	task automatic wait_irq();
		for (int i = 0; i < 100 && irq_out_oe !== 1'b1; i++) @(negedge core_clk);
		cmp1(irq_out_oe, 1'b1);
	endtask

	task automatic pulse(input logic [3:0] ev);
		rf_events = ev;
		@(negedge core_clk);
		rf_events = 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cmp8(interrupt_mask_control, 8'h08);
		cmp1(irq_out_oe, 1'b0);
	endtask

	task automatic t_write();
		wr(8'h78, 8'hF0, 2);
		wait_irq();
		rd(1, 16'h0500);
		cmp8(interrupt_mask_control, 8'hF0);
	endtask

	task automatic t_read();
		wr(8'h68, 8'h00, 1);
		wait_irq();
		rd(2, 16'h05F6);
	endtask

	task automatic t_busy();
		rd(1, 16'h0500);
		rf_busy = 1'b1;
		rd(1, 16'h0700);
		wr(8'h78, 8'h00, 2);
		wait_irq();
		rd(1, 16'h0A00);
		wr(8'h68, 8'h00, 1);
		wait_irq();
		rd(2, 16'h05F6);
		cmp8(interrupt_mask_control, 8'hF0);
		rf_busy = 1'b0;
	endtask

	task automatic t_split();
		config_check_err = 1'b0;
		block_check_code_err = 1'b1;
		wr(8'h78, 8'h00, 1);
		wr(8'h08, 8'h00, 1);
		wait_irq();
		rd(1, 16'h0500);
		cmp8(interrupt_mask_control, 8'h08);
		wr(8'h68, 8'h00, 1);
		wait_irq();
		rd(1, 16'h0500);
		rd(2, 16'h0B0D);
	endtask

	// half a control write left longer than the 21 us window is dropped
	task automatic t_window();
		wr(8'h78, 8'h00, 1);
		repeat (1250) @(negedge core_clk);
		wr(8'h68, 8'h00, 1);
		wait_irq();
		rd(2, 16'h050D);
		cmp8(interrupt_mask_control, 8'h08);
	endtask

	task automatic t_events();
		pulse(4'b0001);
		wait_irq();
		rd(1, 16'h1500);
		wr(8'h78, 8'h18, 2);
		wait_irq();
		rd(1, 16'h0500);
		irq_source_select = 4'h7;
		pulse(4'b1001);
		repeat (10) @(negedge core_clk);
		cmp1(irq_out_oe, 1'b0);
		rd(1, 16'h0500);
		irq_source_select = 4'hF;
	endtask

	task automatic t_self_reset();
		rf_enable_default = 1'b1;
		wr(8'h78, 8'hF1, 2);
		wait_irq();
		rd(1, 16'h0500);
		cmp8(interrupt_mask_control, 8'hF0);
		for (int i = 0; i < 20 && self_reset_active !== 1'b1; i++) @(negedge core_clk);
		cmp1(self_reset_active, 1'b1);
		rd(1, 16'h0700);
		for (int i = 0; i < 400 && self_reset_active !== 1'b0; i++) @(negedge core_clk);
		cmp1(self_reset_active, 1'b0);
		cmp8(interrupt_mask_control, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#1 resetn = 1'b0;
		repeat (12) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		t_reset();
		t_write();
		t_read();
		t_busy();
		t_split();
		t_window();
		t_events();
		t_self_reset();
		final_report();
	end

	// the full sequence needs well under 100 us
	initial begin
		#400000;
		err_count++;
		final_report();
	end
endmodule // host_control_command_access_test

`default_nettype wire
